// File: core/mtar_map.svh
`ifndef MTAR_MAP_SVH
`define MTAR_MAP_SVH
// register byte addresses
`define MTAR_A_CTRL 12'h000
`define MTAR_A_ENA 12'h004
`define MTAR_A_TRIP 12'h008
`define MTAR_A_LIM 12'h00c
`define MTAR_A_DLY_LD 12'h010
`define MTAR_A_DLY_TH 12'h014
`define MTAR_A_DLY_EL 12'h018
`define MTAR_A_THR0 12'h020
`define MTAR_A_THR1 12'h024
`define MTAR_A_THR2 12'h028
`define MTAR_A_THR3 12'h02c
`define MTAR_A_THR4 12'h030
`define MTAR_A_THR5 12'h034
`define MTAR_A_RATED 12'h038
`define MTAR_A_MEAS0 12'h040
`define MTAR_A_MEAS1 12'h044
`define MTAR_A_MEAS2 12'h048
`define MTAR_A_MEAS3 12'h04c
`define MTAR_A_RETRY 12'h050
`define MTAR_A_MAXI 12'h054
`define MTAR_A_MAXT 12'h058
`define MTAR_A_TIME 12'h05c
// protection function bit positions
`define MTAR_F_OVL 0
`define MTAR_F_OVH 1
`define MTAR_F_UNB 2
`define MTAR_F_PLS 3
`define MTAR_F_JAM 4
`define MTAR_F_UND 5
`define MTAR_F_LST 6
`define MTAR_F_OVC 7
`define MTAR_F_STL 8
`define MTAR_F_GND 9
`define MTAR_F_REV 10
`define MTAR_F_CFG 11
// group membership masks
`define MTAR_M_LOAD 12'h1f0
`define MTAR_M_THERM 12'h003
`define MTAR_M_ELEC 12'h60c
`define MTAR_M_VOLATILE 12'hc00
// retry limit codes and defaults
`define MTAR_LIM_UNL 4'hf
`define MTAR_LIM_MAX 4'ha
`define MTAR_LIM_RST 12'h0f0
`define MTAR_DLY_LD_RST 16'h003c
`define MTAR_DLY_TH_RST 16'h01e0
`define MTAR_DLY_EL_RST 16'h04b0
// enable and threshold reset values
`define MTAR_ENA_RST 12'hfff
`define MTAR_THR_RST 16'hffff
// success window, seconds
`define MTAR_OK_SEC 16'h003c
// timebase: 1 s at 50 MHz
`define MTAR_CLK_HZ 50000000
`define MTAR_TICK_SEC 1
`endif

// File: core/mtar_pkg.sv
package mtar_pkg;
   typedef logic [15:0] mtar_val_t;
   typedef logic [11:0] mtar_fn_t;
endpackage

// File: core/mtar_top.sv
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "mtar_map.svh"
// Summary of operation
// RULE_01 - overload resets when thermal capacity below its reset threshold, no margin
// RULE_02 - overheat resets when motor temperature below its reset threshold, no margin
// RULE_03 - unbalance resets when unbalance below unbalance level minus five percent
// RULE_04 - phase loss resets when unbalance below loss level minus five percent
// RULE_05 - jam, overcurrent, stall reset when max current below level minus margin
// RULE_06 - undercurrent resets when average current above level plus five percent
// RULE_07 - long start, reversal, config reset when average below 30% rated current
// RULE_08 - ground resets when ground current below its level minus margin
// RULE_09 - hysteresis margin is five percent of the trip level
// RULE_10 - a disabled function always meets its reset condition
// RULE_11 - load, thermal and electrical groups auto-reset independently
// RULE_12 - auto reset clears only tripped functions whose conditions hold
// RULE_13 - delay starts at trip; reset at later of expiry and conditions met
// RULE_14 - unlimited code retries forever, else stop after limit attempts
// RULE_15 - group fires only when every tripped function's condition holds
// RULE_16 - retry count increments per attempt, clears one minute after success
// RULE_17 - retry limit 0 to 10 or unlimited; defaults 0, unlimited, 0
// RULE_18 - delay 0 to 65535 s; defaults 60, 480, 1200 s
// RULE_19 - report currents, track maximum current with its timestamp
// RULE_20 - report upstream voltage presence
// RULE_21 - reset command clears satisfied functions, others stay tripped
// RULE_22 - trip status kept over power cycle except reversal and configuration
// RULE_23 - conditions and timers evaluated on a common one second tick
// RULE_24 - attempt leaving trips in place fails and counts another retry
module mtar_grp (
   input wire logic hclk, // clock
   input wire logic hresetn, // async reset, low
   input wire logic tick, // one second strobe
   input wire logic new_trip, // a trip entered this group
   input wire logic tripped, // any function of the group tripped
   input wire logic all_ok, // every tripped function may reset
   input wire logic [3:0] limit, // retry limit code
   input wire logic [15:0] delay, // delay seconds
   output logic fire, // one-cycle auto reset strobe
   output logic [3:0] retries // retry count
);
   logic [15:0] sec_q;
   logic [15:0] ok_q;
   logic [3:0] cnt_q;
   logic wait_q;
   logic ready;
   // delay elapsed, conditions met, retry budget left
   assign ready = tripped && (sec_q >= delay) && all_ok // [RULE_13] [RULE_15]
      && ((limit == `MTAR_LIM_UNL) || (cnt_q < limit)); // [RULE_14]
   assign fire = tick && ready; // [RULE_23]
   assign retries = cnt_q;
   // delay timer restarts at each trip
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sec_q <= 16'h0000;
      end else if (new_trip) begin
         sec_q <= 16'h0000; // [RULE_13]
      end else if (tick && tripped && sec_q != 16'hffff) begin
         sec_q <= sec_q + 16'h0001;
      end
   end
   // retry counter and success window
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 4'h0;
         ok_q <= 16'h0000;
         wait_q <= 1'b0;
      end else begin
         if (fire) begin
            if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1; // [RULE_16] [RULE_24]
            ok_q <= 16'h0000;
            wait_q <= 1'b1;
         end else if (new_trip || tripped) begin
            ok_q <= 16'h0000;
         end else if (wait_q && tick) begin
            if (ok_q + 16'h0001 >= `MTAR_OK_SEC) begin
               cnt_q <= 4'h0; // [RULE_16]
               wait_q <= 1'b0;
            end else begin
               ok_q <= ok_q + 16'h0001;
            end
         end
      end
   end
endmodule

module mtar_top
   import mtar_pkg::*;
#(
   parameter int unsigned TICK_CYC = `MTAR_CLK_HZ * `MTAR_TICK_SEC
) (
   input wire logic hclk, // clock
   input wire logic hresetn, // async reset, low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write
   input wire logic [2:0] hsize, // size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // response
   input wire mtar_pkg::mtar_fn_t trip_in, // trip detection pulses
   input wire logic [15:0] i_ph1, // phase 1 current
   input wire logic [15:0] i_ph2, // phase 2 current
   input wire logic [15:0] i_ph3, // phase 3 current
   input wire logic [15:0] i_avg, // average current
   input wire logic [15:0] i_gnd, // ground current
   input wire logic [15:0] unbal, // current unbalance
   input wire logic [15:0] therm_cap, // thermal capacity
   input wire logic [15:0] motor_temp, // motor temperature
   input wire logic upstream_v, // upstream voltage pin
   input wire logic cold_start, // power-up, not a warm restart
   input wire mtar_pkg::mtar_fn_t trip_keep, // retained trips after power cycle
   output mtar_pkg::mtar_fn_t tripped, // tripped status
   output logic upstream_ok // upstream voltage present
);
   import mtar_pkg::*;
   // -----------------------------------------------------------------
   // bus slave
   // -----------------------------------------------------------------
   logic [11:0] a_q;
   logic w_q;
   logic [31:0] rd_q;
   logic man_rst, clr_max;
   mtar_fn_t ena_q, trip_q, ok;
   logic [11:0] lim_q;
   mtar_val_t dly_q [3];
   mtar_val_t thr_q [6];
   mtar_val_t rated_q;
   logic [31:0] time_q, maxt_q;
   mtar_val_t imax_q, imax_now;
   logic [2:0] fire;
   logic [3:0] rtr [3];
   logic [31:0] tick_q;
   logic tick;
   logic up_s1, up_s2;
   logic keep_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rd_q;
   // address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_q <= 12'h000;
         w_q <= 1'b0;
      end else if (hready) begin
         a_q <= haddr[11:0];
         w_q <= hsel && htrans[1] && hwrite;
      end
   end
   // read data in address phase, unmapped reads zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_q <= 32'h00000000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         unique case (haddr[11:0])
            `MTAR_A_ENA: rd_q <= {20'h00000, ena_q};
            `MTAR_A_TRIP: rd_q <= {20'h00000, trip_q};
            `MTAR_A_LIM: rd_q <= {20'h00000, lim_q};
            `MTAR_A_DLY_LD: rd_q <= {16'h0000, dly_q[0]};
            `MTAR_A_DLY_TH: rd_q <= {16'h0000, dly_q[1]};
            `MTAR_A_DLY_EL: rd_q <= {16'h0000, dly_q[2]};
            `MTAR_A_THR0: rd_q <= {16'h0000, thr_q[0]};
            `MTAR_A_THR1: rd_q <= {16'h0000, thr_q[1]};
            `MTAR_A_THR2: rd_q <= {16'h0000, thr_q[2]};
            `MTAR_A_THR3: rd_q <= {16'h0000, thr_q[3]};
            `MTAR_A_THR4: rd_q <= {16'h0000, thr_q[4]};
            `MTAR_A_THR5: rd_q <= {16'h0000, thr_q[5]};
            `MTAR_A_RATED: rd_q <= {16'h0000, rated_q};
            `MTAR_A_MEAS0: rd_q <= {i_ph2, i_ph1}; // [RULE_19]
            `MTAR_A_MEAS1: rd_q <= {i_avg, i_ph3};
            `MTAR_A_MEAS2: rd_q <= {i_gnd, unbal};
            `MTAR_A_MEAS3: rd_q <= {15'h0000, upstream_ok, 16'h0000}; // [RULE_20]
            `MTAR_A_RETRY: rd_q <= {20'h00000, rtr[2], rtr[1], rtr[0]};
            `MTAR_A_MAXI: rd_q <= {16'h0000, imax_q};
            `MTAR_A_MAXT: rd_q <= maxt_q;
            `MTAR_A_TIME: rd_q <= time_q;
            default: rd_q <= 32'h00000000;
         endcase
      end
   end
   assign man_rst = w_q && a_q == `MTAR_A_CTRL && hwdata[0];
   assign clr_max = w_q && a_q == `MTAR_A_CTRL && hwdata[1];
   // configuration registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ena_q <= `MTAR_ENA_RST;
         lim_q <= `MTAR_LIM_RST; // [RULE_17]
         dly_q[0] <= `MTAR_DLY_LD_RST; // [RULE_18]
         dly_q[1] <= `MTAR_DLY_TH_RST;
         dly_q[2] <= `MTAR_DLY_EL_RST;
         for (int k = 0; k < 6; k++) thr_q[k] <= `MTAR_THR_RST;
         rated_q <= 16'h0000;
      end else if (w_q) begin
         unique case (a_q)
            `MTAR_A_ENA: ena_q <= hwdata[11:0];
            `MTAR_A_LIM: begin
               for (int g = 0; g < 3; g++) begin
                  // out-of-range codes other than unlimited are clamped
                  if (hwdata[4*g +: 4] <= `MTAR_LIM_MAX || hwdata[4*g +: 4] == `MTAR_LIM_UNL)
                     lim_q[4*g +: 4] <= hwdata[4*g +: 4]; // [RULE_17]
                  else
                     lim_q[4*g +: 4] <= `MTAR_LIM_MAX;
               end
            end
            `MTAR_A_DLY_LD: dly_q[0] <= hwdata[15:0];
            `MTAR_A_DLY_TH: dly_q[1] <= hwdata[15:0];
            `MTAR_A_DLY_EL: dly_q[2] <= hwdata[15:0];
            `MTAR_A_THR0: thr_q[0] <= hwdata[15:0];
            `MTAR_A_THR1: thr_q[1] <= hwdata[15:0];
            `MTAR_A_THR2: thr_q[2] <= hwdata[15:0];
            `MTAR_A_THR3: thr_q[3] <= hwdata[15:0];
            `MTAR_A_THR4: thr_q[4] <= hwdata[15:0];
            `MTAR_A_THR5: thr_q[5] <= hwdata[15:0];
            `MTAR_A_RATED: rated_q <= hwdata[15:0];
            default: ;
         endcase
      end
   end
   // -----------------------------------------------------------------
   // timebase, upstream voltage, maximum current
   // -----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_q <= 32'h00000000;
         time_q <= 32'h00000000;
      end else if (tick) begin
         tick_q <= 32'h00000000;
         time_q <= time_q + 32'h00000001;
      end else begin
         tick_q <= tick_q + 32'h00000001;
      end
   end
   assign tick = (tick_q == TICK_CYC - 1); // [RULE_23]
   // two-stage synchroniser on the upstream pin
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         up_s1 <= 1'b0;
         up_s2 <= 1'b0;
      end else begin
         up_s1 <= upstream_v;
         up_s2 <= up_s1;
      end
   end
   assign upstream_ok = up_s2; // [RULE_20]
   assign imax_now = (i_ph1 > i_ph2) ? ((i_ph1 > i_ph3) ? i_ph1 : i_ph3)
      : ((i_ph2 > i_ph3) ? i_ph2 : i_ph3);
   // highest current since clear, with its time
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         imax_q <= 16'h0000;
         maxt_q <= 32'h00000000;
      end else if (clr_max) begin
         imax_q <= 16'h0000;
         maxt_q <= time_q;
      end else if (imax_now > imax_q) begin
         imax_q <= imax_now; // [RULE_19]
         maxt_q <= time_q;
      end
   end
   // -----------------------------------------------------------------
   // reset conditions
   // -----------------------------------------------------------------
   function automatic logic below_hys(input logic [15:0] v, input logic [15:0] lvl);
      logic [20:0] lhs, rhs;
      lhs = {5'h00, v} * 21'h000014;
      rhs = {5'h00, lvl} * 21'h000013; // [RULE_09] v < 0.95 lvl
      return lhs < rhs;
   endfunction
   function automatic logic above_hys(input logic [15:0] v, input logic [15:0] lvl);
      logic [20:0] lhs, rhs;
      lhs = {5'h00, v} * 21'h000014;
      rhs = {5'h00, lvl} * 21'h000015; // [RULE_09] v > 1.05 lvl
      return lhs > rhs;
   endfunction
   logic low_avg;
   logic [22:0] avg10, rat3;
   assign avg10 = {7'h00, i_avg} * 23'h00000a;
   assign rat3 = {7'h00, rated_q} * 23'h000003;
   assign low_avg = avg10 < rat3; // [RULE_07]
   // thresholds: 0 thermal, 1 overheat, 2 unbalance, 3 loss, 4 jam/ovc/stall, 5 under/ground
   logic [11:0] cond;
   always_comb begin
      cond = 12'h000;
      cond[`MTAR_F_OVL] = therm_cap < thr_q[0]; // [RULE_01]
      cond[`MTAR_F_OVH] = motor_temp < thr_q[1]; // [RULE_02]
      cond[`MTAR_F_UNB] = below_hys(unbal, thr_q[2]); // [RULE_03]
      cond[`MTAR_F_PLS] = below_hys(unbal, thr_q[3]); // [RULE_04]
      cond[`MTAR_F_JAM] = below_hys(imax_now, thr_q[4]); // [RULE_05]
      cond[`MTAR_F_OVC] = below_hys(imax_now, thr_q[4]); // [RULE_05]
      cond[`MTAR_F_STL] = below_hys(imax_now, thr_q[4]); // [RULE_05]
      cond[`MTAR_F_UND] = above_hys(i_avg, thr_q[5]); // [RULE_06]
      cond[`MTAR_F_LST] = low_avg;
      cond[`MTAR_F_REV] = low_avg;
      cond[`MTAR_F_CFG] = low_avg;
      cond[`MTAR_F_GND] = below_hys(i_gnd, thr_q[5]); // [RULE_08]
   end
   assign ok = cond | ~ena_q; // [RULE_10]
   // -----------------------------------------------------------------
   // auto reset groups and trip status
   // -----------------------------------------------------------------
   logic [11:0] gmask [3];
   assign gmask[0] = `MTAR_M_LOAD;
   assign gmask[1] = `MTAR_M_THERM;
   assign gmask[2] = `MTAR_M_ELEC;
   mtar_fn_t clr;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_grp
         mtar_grp u_grp ( // [RULE_11]
            .hclk(hclk),
            .hresetn(hresetn),
            .tick(tick),
            .new_trip(|(trip_in & ena_q & gmask[gi])),
            .tripped(|(trip_q & gmask[gi])),
            .all_ok(((trip_q & gmask[gi]) & ~ok) == 12'h000), // [RULE_15]
            .limit(lim_q[4*gi +: 4]),
            .delay(dly_q[gi]),
            .fire(fire[gi]),
            .retries(rtr[gi])
         );
      end
   endgenerate
   // a reset request clears only satisfied functions of its scope
   assign clr = ok & ((man_rst ? 12'hfff : 12'h000) | (fire[0] ? gmask[0] : 12'h000)
      | (fire[1] ? gmask[1] : 12'h000) | (fire[2] ? gmask[2] : 12'h000)); // [RULE_12] [RULE_21]
   // retained trips loaded one cycle after reset release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trip_q <= 12'h000;
         keep_q <= 1'b1;
      end else begin
         keep_q <= 1'b0;
         if (keep_q)
            trip_q <= cold_start ? (trip_keep & ~`MTAR_M_VOLATILE) : trip_keep; // [RULE_22]
         else
            trip_q <= (trip_q & ~clr) | (trip_in & ena_q); // set wins over clear
      end
   end
   assign tripped = trip_q;
   a_clear_ok: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_21]
      (!keep_q && $past(!keep_q) && $fell(trip_q[`MTAR_F_JAM])) |-> $past(ok[`MTAR_F_JAM]))
      else $error("jam cleared without condition");
   a_disabled_ok: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_10]
      (ena_q != `MTAR_ENA_RST) |-> ((~ena_q & ~ok) == 12'h000))
      else $error("disabled function not satisfied");
   a_fire_tick: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_23]
      |fire |-> tick)
      else $error("auto reset off tick");
   a_fire_all_ok: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_15]
      (fire[0] && !(|(trip_in & `MTAR_M_LOAD))) |=> !(|(trip_q & `MTAR_M_LOAD)))
      else $error("load group still tripped after auto reset");
   a_lim_range: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_17]
      lim_q[3:0] <= `MTAR_LIM_MAX || lim_q[3:0] == `MTAR_LIM_UNL)
      else $error("load limit out of range");
   a_retry_stop: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_14]
      (fire[0] && lim_q[3:0] != `MTAR_LIM_UNL) |-> rtr[0] < lim_q[3:0])
      else $error("load retry beyond limit");
   a_retry_inc: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_16]
      (fire[0] && rtr[0] != 4'hf) |=> rtr[0] == $past(rtr[0]) + 4'h1)
      else $error("retry count not incremented");
   a_max_track: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_19]
      (!clr_max && imax_now > imax_q) |=> imax_q == $past(imax_now))
      else $error("maximum current not tracked");
   a_up_sync: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_20]
      upstream_ok == $past(upstream_v, 2))
      else $error("upstream status mismatch");
endmodule

// File: tb/mtar_host.sv
`timescale 1ns/1ps
module mtar_host (
   input wire logic hclk, // bus clock
   input wire logic hready, // bus ready from the slave
   output logic hsel, // slave select
   output logic [31:0] haddr, // byte address
   output logic [1:0] htrans, // transfer type
   output logic hwrite, // write, not read
   output logic [2:0] hsize, // always one word
   output logic [31:0] hwdata, // write data
   output logic rd_ph // a read data phase is open
);
   //--------------------------------------------
   // supervisory master: idle bus at time zero
   //--------------------------------------------
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      rd_ph = 1'b0;
   end

   // one single word transfer; both phases wait on hready, no latency assumed.
   // released write data is inverted so a slave that samples late sees a wrong value
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         @(posedge hclk);
      end
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      rd_ph <= ~w;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         @(posedge hclk);
      end
      rd_ph <= 1'b0;
      hwdata <= ~d;
   endtask
endmodule

// File: tb/mtar_top_tb.sv
`timescale 1ns/1ps
`include "mtar_map.svh"
module mtar_top_tb;
   import mtar_pkg::*;
   localparam int unsigned TCYC = 10; // clock cycles per timebase second
   logic hclk, hresetn, hsel, hwrite, hreadyout, rd_ph, upstream_v, upstream_ok, cold_start;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   mtar_fn_t trip_in, trip_keep, tripped;
   mtar_val_t meas [8]; // therm, temp, unbal, ph1, ph2, ph3, avg, gnd
   logic [43:0] exp_q [$]; // {address, expected word}
   int bad_count = 0;
   int n_checks = 0;
   int tbl [12][4]; // function bit, measurement, value kept tripped, value cleared
   int k;

   mtar_host i_host (.hclk(hclk), .hready(hreadyout), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .rd_ph(rd_ph));

   mtar_top #(.TICK_CYC(TCYC)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .trip_in(trip_in),
      .i_ph1(meas[3]), .i_ph2(meas[4]), .i_ph3(meas[5]), .i_avg(meas[6]), .i_gnd(meas[7]),
      .unbal(meas[2]), .therm_cap(meas[0]), .motor_temp(meas[1]), .upstream_v(upstream_v),
      .cold_start(cold_start), .trip_keep(trip_keep), .tripped(tripped),
      .upstream_ok(upstream_ok)
   );

   //--------------------------------------------
   // compare, bus and timing helpers
   //--------------------------------------------
   task automatic chk_word(input logic [11:0] a, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value reg %h expected %h seen %h", a, e, s);
      end
   endtask

   // tripped is sampled mid-cycle, then the caller is back on a rising edge
   task automatic chk_trip(input mtar_fn_t e);
      @(negedge hclk);
      n_checks++;
      if (tripped !== e) begin
         bad_count++;
         $display("wrong value tripped expected %h seen %h", e, tripped);
      end
      @(posedge hclk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back({a, e});
      i_host.xfer(1'b0, a, 32'h0);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      i_host.xfer(1'b1, a, d);
   endtask

   task automatic tk(input int n);
      repeat (n) @(posedge hclk);
   endtask

   task automatic trip(input int b);
      trip_in <= 12'h1 << b;
      tk(1);
      trip_in <= 12'h0;
      tk(1);
   endtask

   // bounded wait for the masked functions to leave the tripped state
   task automatic wait_clr(input mtar_fn_t m, input int lim);
      for (int i = 0; i < lim; i++) begin
         @(negedge hclk);
         if ((tripped & m) === 12'h0) break;
      end
      @(posedge hclk);
   endtask

   task automatic done(input string t);
      $display("test %s finished", t);
   endtask

   task automatic end_sim;
      // a read that was noted but never answered counts as a mismatch
      if (exp_q.size() != 0) begin
         bad_count++;
         $display("wrong value pending reads expected 0 seen %0d", exp_q.size());
      end
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // read monitor: each read answer is matched with the oldest note
   always @(posedge hclk) begin
      if (rd_ph === 1'b1 && hreadyout === 1'b1) begin
         if (exp_q.size() == 0) begin
            bad_count++;
            $display("wrong value read data expected none seen %h", hrdata);
         end else begin
            chk_word(exp_q[0][43:32], exp_q[0][31:0], hrdata);
            void'(exp_q.pop_front());
         end
      end
   end

   //--------------------------------------------
   // clock, watchdog and test sequence
   //--------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   initial begin
      tk(20000);
      bad_count++;
      end_sim();
   end

   initial begin
      hresetn = 1'b0;
      trip_in = 12'h0;
      trip_keep = 12'h0;
      cold_start = 1'b1;
      upstream_v = 1'b0;
      meas = '{default: 16'h0};
      tbl = '{'{0, 0, 16'h64, 16'h63}, // thermal capacity, no margin
         '{1, 1, 16'h64, 16'h63}, // motor temperature, no margin
         '{2, 2, 16'h5f, 16'h5e}, // unbalance less five percent
         '{3, 2, 16'h5f, 16'h5e}, // phase loss less five percent
         '{4, 3, 16'h5f, 16'h5e}, // jam on largest phase
         '{7, 4, 16'h5f, 16'h5e}, // overcurrent on largest phase
         '{8, 5, 16'h5f, 16'h5e}, // stall on largest phase
         '{5, 6, 16'h69, 16'h6a}, // undercurrent plus five percent
         '{6, 6, 16'h1e, 16'h1d}, // long start, 30 percent of rated
         '{10, 6, 16'h1e, 16'h1d}, // reversal, 30 percent of rated
         '{11, 6, 16'h1e, 16'h1d}, // configuration, 30 percent of rated
         '{9, 7, 16'h5f, 16'h5e}}; // ground less five percent
      void'($urandom(29371));
      tk(2);
      hresetn <= 1'b1;
      tk(1);
      // reset values, legal limit codes, unmapped place
      rd(`MTAR_A_LIM, 32'h0f0);
      rd(`MTAR_A_DLY_LD, 32'h3c);
      rd(`MTAR_A_DLY_TH, 32'h1e0);
      rd(`MTAR_A_DLY_EL, 32'h4b0);
      rd(`MTAR_A_ENA, 32'hfff);
      wr(`MTAR_A_LIM, 32'ha5f);
      rd(`MTAR_A_LIM, 32'ha5f);
      wr(`MTAR_A_LIM, 32'hb00 | 32'($urandom_range(14, 11)));
      rd(`MTAR_A_LIM, 32'ha0a);
      wr(`MTAR_A_LIM, 32'h0f0);
      wr(12'h0fc, 32'hffff_ffff);
      rd(12'h0fc, 32'h0);
      done("defaults");
      // every level 100, rated current 100
      for (k = 0; k < 6; k++) wr(`MTAR_A_THR0 + 12'(4 * k), 32'h64);
      wr(`MTAR_A_RATED, 32'h64);
      // each function: boundary value keeps it tripped, one step further clears it
      for (k = 0; k < 12; k++) begin
         meas[tbl[k][1]] <= 16'(tbl[k][2]);
         tk(TCYC + 2);
         trip(tbl[k][0]);
         wr(`MTAR_A_CTRL, 32'h1);
         rd(`MTAR_A_TRIP, 32'h1 << tbl[k][0]);
         meas[tbl[k][1]] <= 16'(tbl[k][3]);
         tk(TCYC + 2);
         wr(`MTAR_A_CTRL, 32'h1);
         rd(`MTAR_A_TRIP, 32'h0);
      end
      done("conditions");
      // a random function is tripped, then disabled, then reset
      k = $urandom_range(11);
      meas[tbl[k][1]] <= 16'(tbl[k][2]);
      tk(TCYC + 2);
      trip(tbl[k][0]);
      wr(`MTAR_A_ENA, 32'hfff ^ (32'h1 << tbl[k][0]));
      tk(TCYC + 2);
      wr(`MTAR_A_CTRL, 32'h1);
      rd(`MTAR_A_TRIP, 32'h0);
      wr(`MTAR_A_ENA, 32'hfff);
      done("disabled");
      // load group auto reset: delay 3 s, two retries
      wr(`MTAR_A_LIM, 32'h0f2);
      wr(`MTAR_A_DLY_LD, 32'h3);
      meas[0] <= 16'h0;
      meas[3] <= 16'h5f;
      meas[4] <= 16'h0;
      meas[5] <= 16'h0;
      trip(0);
      trip(4);
      trip(8);
      tk(6 * TCYC);
      chk_trip(12'h111);
      rd(`MTAR_A_RETRY, 32'h0);
      meas[3] <= 16'h5e;
      wait_clr(12'h110, 4 * TCYC);
      chk_trip(12'h001);
      rd(`MTAR_A_RETRY, 32'h1);
      wr(`MTAR_A_CTRL, 32'h1);
      trip(4);
      tk(12);
      chk_trip(12'h010);
      wait_clr(12'h010, 4 * TCYC);
      chk_trip(12'h000);
      rd(`MTAR_A_RETRY, 32'h2);
      trip(4);
      tk(8 * TCYC);
      chk_trip(12'h010);
      wr(`MTAR_A_LIM, 32'h0ff);
      wait_clr(12'h010, 3 * TCYC);
      chk_trip(12'h000);
      rd(`MTAR_A_RETRY, 32'h3);
      tk(62 * TCYC);
      rd(`MTAR_A_RETRY, 32'h0);
      done("auto reset");
      // measured currents, maximum and upstream voltage
      meas[3] <= 16'h0123;
      meas[4] <= 16'h0045;
      meas[5] <= 16'h0067;
      meas[6] <= 16'h0123;
      upstream_v <= 1'b1;
      wr(`MTAR_A_CTRL, 32'h2);
      tk(TCYC + 2);
      rd(`MTAR_A_MEAS0, 32'h0045_0123);
      rd(`MTAR_A_MEAS1, 32'h0123_0067);
      rd(`MTAR_A_MAXI, 32'h0000_0123);
      rd(`MTAR_A_MEAS3, 32'h0001_0000);
      upstream_v <= 1'b0;
      tk(4);
      rd(`MTAR_A_MEAS3, 32'h0);
      done("monitoring");
      // power cycles: cold start drops reversal and configuration, warm keeps all
      trip_keep <= 12'hfff;
      hresetn <= 1'b0;
      tk(2);
      hresetn <= 1'b1;
      tk(2);
      chk_trip(12'h3ff);
      cold_start <= 1'b0;
      trip_keep <= 12'h8a5;
      hresetn <= 1'b0;
      tk(2);
      hresetn <= 1'b1;
      tk(2);
      chk_trip(12'h8a5);
      // a new maximum two seconds after release carries timestamp 2
      tk(2 * TCYC);
      meas[3] <= 16'h0456;
      tk(2);
      rd(`MTAR_A_MAXI, 32'h0456);
      rd(`MTAR_A_MAXT, 32'h2);
      done("power cycle");
      tk(4);
      end_sim();
   end
endmodule
